// [rtl/smp_defs.svh]
`ifndef SMP_DEFS_SVH
`define SMP_DEFS_SVH
// Summary of operation
// R1 - one byte goes out and one byte comes in during each transfer
// R2 - software picks master role (drives clock) or slave role (follows clock)
// R3 - clock idle level and sampling phase are programmable, four formats
// R4 - master drives the master-out line, slave samples it
// R5 - selected slave drives the master-in line, master samples it
// R6 - bytes shift most significant bit first on both lines
// R7 - master gives exactly eight clock pulses per byte, one bit each
// R8 - master keeps a slave's select low for the whole message
// R9 - unselected slave releases its master-in output
// R10 - master selects only one slave at a time
// R11 - in master role a low select level flags a mode fault
// R12 - master with select disabled ignores select, never flags a fault
// R13 - slave with phase and select-disable set is always selected
// R14 - clearing select-disable leaves the fault flag alone
// R15 - software keeps select-disable clear while phase is zero
// R16 - rate code 1..6 divides the clock by 4..128; 0 and 7 unused
// R17 - mode fault flag can raise an interrupt request
// R18 - write collision flag guards the data register during transfers
// R19 - select low in master role with select enabled sets the fault flag
// R20 - mode fault requests interrupt, clears enable and master bits
// R21 - data write mid-transfer sets collision flag, transfer continues
// R22 - with phase zero, select toggles high then low between bytes
// R23 - master data write while idle loads shifter, starts eight clocks

// register addresses
`define SMP_ADDR_CTRL 2'h0
`define SMP_ADDR_STAT 2'h1
`define SMP_ADDR_DATA 2'h2

// control register fields
`define SMP_CTL_RATE0 0
`define SMP_CTL_RATE1 1
`define SMP_CTL_PHASE 2
`define SMP_CTL_POLARITY 3
`define SMP_CTL_MASTER 4
`define SMP_CTL_DISSEL 5
`define SMP_CTL_ENABLE 6
`define SMP_CTL_RATE2 7
`define SMP_CTRL_RST 8'h00

// status register fields
`define SMP_STA_FAULT 4
`define SMP_STA_COLL 6
`define SMP_STA_DONE 7

// half serial period minus one, in clock cycles, per rate code
`define SMP_HALF_DIV4 7'h01
`define SMP_HALF_DIV8 7'h03
`define SMP_HALF_DIV16 7'h07
`define SMP_HALF_DIV32 7'h0F
`define SMP_HALF_DIV64 7'h1F
`define SMP_HALF_DIV128 7'h3F

// clock edges per byte
`define SMP_LAST_EDGE 5'h0F
`define SMP_EDGES 5'h10

// synchronised pin slots
`define SMP_NPINS 4
`define SMP_PIN_SCK 0
`define SMP_PIN_MOSI 1
`define SMP_PIN_MISO 2
`define SMP_PIN_SSN 3
`define SMP_SYNC_RST 4'h8
`endif

// [rtl/smp_pkg.sv]
package smp_pkg;
   typedef enum logic [0:0] {
      ST_IDLE,
      ST_SHIFT
   } smp_state_t;
endpackage // smp_pkg

// [rtl/smp_sync_if.sv]
`timescale 1ns/100ps
`include "smp_defs.svh"
interface smp_sync_if;
   logic [`SMP_NPINS-1:0] raw;
   logic [`SMP_NPINS-1:0] sync;
   modport syn (input raw, output sync);
   modport top (output raw, input sync);
endinterface // smp_sync_if

// [rtl/smp_sync.sv]
`timescale 1ns/100ps
`include "smp_defs.svh"
module smp_sync (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // pins in, synchronised pins out
   smp_sync_if.syn port
);
   logic [`SMP_NPINS-1:0] meta_q;
   logic [`SMP_NPINS-1:0] sync_q;

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta_q <= `SMP_SYNC_RST;
         sync_q <= `SMP_SYNC_RST;
      end
      else
      begin
         meta_q <= port.raw;
         sync_q <= meta_q;
      end
   end

   assign port.sync = sync_q;
endmodule // smp_sync

// [rtl/smp_top.sv]
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`include "smp_defs.svh"
module smp_top (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // register port
   input wire logic [1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // interrupt request
   output logic irq_o,
   // serial clock pin
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe_o,
   // master-out pin
   input wire logic mosi_i,
   output logic mosi_o,
   output logic mosi_oe_o,
   // master-in pin
   input wire logic miso_i,
   output logic miso_o,
   output logic miso_oe_o,
   // slave select pin
   input wire logic ss_n_i
);
   smp_sync_if pins_if ();
   smp_pkg::smp_state_t state_q;
   logic [7:0] ctrl_q;
   logic [7:0] sh_q;
   logic [7:0] rx_q;
   logic [7:0] rdata_q;
   logic [7:0] stat_vec;
   logic [6:0] div_q;
   logic [6:0] half_m1;
   logic [4:0] edge_cnt_q;
   logic [2:0] rate;
   logic smp_q, sck_q, sck_prev_q, irq_q;
   logic fault_q, coll_q, done_q;
   logic fault_arm_q, coll_arm_q, done_arm_q;
   logic sck_s, mosi_s, miso_s, ss_n_s;
   logic enable, is_master, pol, pha, dissel, rate_ok;
   logic busy, sel, fault, abort, start;
   logic wr_ctrl, wr_data, rd_stat, acc_data;
   logic m_edge, s_edge, ev, lead, sample, last, din, shin;
   logic [7:0] shifted;

   assign pins_if.raw = {ss_n_i, miso_i, mosi_i, sck_i};

   smp_sync u_sync (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .port(pins_if.syn)
   );

   assign sck_s = pins_if.sync[`SMP_PIN_SCK];
   assign mosi_s = pins_if.sync[`SMP_PIN_MOSI];
   assign miso_s = pins_if.sync[`SMP_PIN_MISO];
   assign ss_n_s = pins_if.sync[`SMP_PIN_SSN];

   assign enable = ctrl_q[`SMP_CTL_ENABLE];
   assign is_master = ctrl_q[`SMP_CTL_MASTER]; // R2
   assign pol = ctrl_q[`SMP_CTL_POLARITY];
   assign pha = ctrl_q[`SMP_CTL_PHASE];
   assign dissel = ctrl_q[`SMP_CTL_DISSEL];
   assign rate = {ctrl_q[`SMP_CTL_RATE2], ctrl_q[`SMP_CTL_RATE1], ctrl_q[`SMP_CTL_RATE0]};

   assign wr_ctrl = reg_wr_i && (reg_addr_i == `SMP_ADDR_CTRL);
   assign wr_data = reg_wr_i && (reg_addr_i == `SMP_ADDR_DATA);
   assign rd_stat = reg_rd_i && (reg_addr_i == `SMP_ADDR_STAT);
   assign acc_data = (reg_wr_i || reg_rd_i) && (reg_addr_i == `SMP_ADDR_DATA);

   assign busy = (state_q == smp_pkg::ST_SHIFT);
   // phase 1 plus select-disable: select pin level no longer matters
   assign sel = !ss_n_s || (pha && dissel); // R13
   assign fault = enable && is_master && !dissel && !ss_n_s; // R11 R12 R19
   // slave deselect mid-byte drops the partial byte
   assign abort = fault || !enable || (!is_master && !sel); // R8 R22
   assign start = wr_data && !busy && enable && is_master && rate_ok; // R23

   // codes 0 and 7 have no rate, so a master write there never starts
   always_comb
   begin
      rate_ok = 1'b1;
      unique case (rate)
         3'h1: half_m1 = `SMP_HALF_DIV4; // R16
         3'h2: half_m1 = `SMP_HALF_DIV8;
         3'h3: half_m1 = `SMP_HALF_DIV16;
         3'h4: half_m1 = `SMP_HALF_DIV32;
         3'h5: half_m1 = `SMP_HALF_DIV64;
         3'h6: half_m1 = `SMP_HALF_DIV128;
         default:
         begin
            half_m1 = 7'h00;
            rate_ok = 1'b0;
         end
      endcase
   end

   assign m_edge = is_master && busy && (div_q == half_m1);
   assign s_edge = !is_master && enable && sel && (sck_s != sck_prev_q);
   assign ev = m_edge || s_edge;
   assign lead = is_master ? (sck_q == pol) : (sck_s != pol); // R3
   assign sample = pha ? !lead : lead; // R3
   assign last = (edge_cnt_q == `SMP_LAST_EDGE);
   assign din = is_master ? miso_s : mosi_s; // R4 R5
   // phase 1 samples on the last edge itself, so take the live bit there
   assign shin = (pha && last) ? din : smp_q;
   assign shifted = {sh_q[6:0], shin}; // R6

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sh_q <= 8'h00;
         smp_q <= 1'b0;
         rx_q <= 8'h00;
      end
      else if (wr_data && !busy)
         sh_q <= reg_wdata_i; // R23
      else if (ev && !abort)
      begin
         if (sample)
            smp_q <= din; // R1
         // no shift on the first phase 1 edge: b7 already sits on mosi from the load
         if (!sample && edge_cnt_q != 5'h00)
            sh_q <= shifted; // R1 R6
         if (last)
            rx_q <= shifted;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_q <= smp_pkg::ST_IDLE;
         edge_cnt_q <= 5'h00;
      end
      else if (abort)
      begin
         state_q <= smp_pkg::ST_IDLE;
         edge_cnt_q <= 5'h00;
      end
      else if (start)
      begin
         state_q <= smp_pkg::ST_SHIFT;
         edge_cnt_q <= 5'h00;
      end
      else if (ev)
      begin
         if (last)
         begin
            state_q <= smp_pkg::ST_IDLE; // R7
            edge_cnt_q <= 5'h00;
         end
         else
         begin
            state_q <= smp_pkg::ST_SHIFT;
            edge_cnt_q <= edge_cnt_q + 5'h01;
         end
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         div_q <= 7'h00;
         sck_q <= 1'b0;
         sck_prev_q <= 1'b0;
      end
      else
      begin
         sck_prev_q <= sck_s;
         if (!busy || start)
         begin
            div_q <= 7'h00;
            sck_q <= pol; // R3
         end
         else if (m_edge)
         begin
            div_q <= 7'h00;
            sck_q <= !sck_q; // R7 R16
         end
         else
            div_q <= div_q + 7'h01;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         ctrl_q <= `SMP_CTRL_RST;
      else
      begin
         if (wr_ctrl)
            ctrl_q <= reg_wdata_i;
         if (fault)
         begin
            ctrl_q[`SMP_CTL_ENABLE] <= 1'b0; // R20
            ctrl_q[`SMP_CTL_MASTER] <= 1'b0; // R20
         end
      end
   end

   // fault clears by status read then control write; a new fault wins
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         fault_q <= 1'b0;
         fault_arm_q <= 1'b0;
      end
      else
      begin
         if (fault)
            fault_q <= 1'b1; // R19
         else if (wr_ctrl && fault_arm_q)
            fault_q <= 1'b0; // R14
         if (rd_stat && fault_q)
            fault_arm_q <= 1'b1;
         else if (wr_ctrl)
            fault_arm_q <= 1'b0;
      end
   end

   // collision and done clear by status read then data access
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         coll_q <= 1'b0;
         coll_arm_q <= 1'b0;
         done_q <= 1'b0;
         done_arm_q <= 1'b0;
      end
      else
      begin
         if (wr_data && busy)
            coll_q <= 1'b1; // R18 R21
         else if (acc_data && coll_arm_q)
            coll_q <= 1'b0;
         if (ev && last && !abort)
            done_q <= 1'b1;
         else if (acc_data && done_arm_q)
            done_q <= 1'b0;
         if (rd_stat && coll_q)
            coll_arm_q <= 1'b1;
         else if (acc_data)
            coll_arm_q <= 1'b0;
         if (rd_stat && done_q)
            done_arm_q <= 1'b1;
         else if (acc_data)
            done_arm_q <= 1'b0;
      end
   end

   always_comb
   begin
      stat_vec = 8'h00;
      stat_vec[`SMP_STA_FAULT] = fault_q;
      stat_vec[`SMP_STA_COLL] = coll_q;
      stat_vec[`SMP_STA_DONE] = done_q;
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rdata_q <= 8'h00;
         irq_q <= 1'b0;
      end
      else
      begin
         // collision stays off the request line on purpose
         irq_q <= fault_q || done_q; // R17 R20 R21
         if (reg_rd_i)
         begin
            unique case (reg_addr_i)
               `SMP_ADDR_CTRL: rdata_q <= ctrl_q;
               `SMP_ADDR_STAT: rdata_q <= stat_vec;
               `SMP_ADDR_DATA: rdata_q <= rx_q;
               default: rdata_q <= 8'h00;
            endcase
         end
         else
            rdata_q <= 8'h00;
      end
   end

   assign reg_rdata_o = rdata_q;
   assign irq_o = irq_q;
   assign sck_o = sck_q;
   assign sck_oe_o = enable && is_master; // R2
   assign mosi_o = sh_q[7]; // R4 R6
   assign mosi_oe_o = enable && is_master; // R4
   assign miso_o = sh_q[7]; // R5
   assign miso_oe_o = enable && !is_master && sel; // R5 R9 R10

   // checking helpers
   logic [4:0] tog_q;
   logic [6:0] gap_q;
   logic sck_d_q, fin_q;

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         tog_q <= 5'h00;
         gap_q <= 7'h00;
         sck_d_q <= 1'b0;
         fin_q <= 1'b0;
      end
      else
      begin
         sck_d_q <= sck_o;
         fin_q <= ev && last && !abort;
         if (start)
            tog_q <= 5'h00;
         else if (sck_o != sck_d_q)
            tog_q <= tog_q + 5'h01;
         if (start)
            gap_q <= 7'h00;
         else if (sck_o != sck_d_q)
            gap_q <= 7'h01;
         else
            gap_q <= gap_q + 7'h01;
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   property p_eight_pulses;
      fin_q && is_master |=> tog_q == `SMP_EDGES;
   endproperty
   a_eight_pulses: assert property (p_eight_pulses) else $error("pulse count not eight"); // R7

   property p_rate;
      $changed(sck_o) && busy && $past(busy) && $stable(rate) |-> $past(gap_q) == half_m1;
   endproperty
   a_rate: assert property (p_rate) else $error("serial clock half period wrong"); // R16

   property p_idle_level;
      is_master && !busy && !$past(busy) && $stable(pol) |-> sck_o == pol;
   endproperty
   a_idle_level: assert property (p_idle_level) else $error("idle clock level wrong"); // R3

   property p_msb_first;
      start |=> mosi_o == $past(reg_wdata_i[7]);
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("first bit not msb"); // R6

   property p_start;
      start |=> busy && sh_q == $past(reg_wdata_i);
   endproperty
   a_start: assert property (p_start) else $error("idle data write did not start"); // R23

   property p_release;
      ss_n_s && !dissel |-> !miso_oe_o;
   endproperty
   a_release: assert property (p_release) else $error("unselected slave drives output"); // R9

   property p_always_sel;
      !is_master && enable && pha && dissel |-> miso_oe_o;
   endproperty
   a_always_sel: assert property (p_always_sel) else $error("forced select not honoured"); // R13

   property p_fault_set;
      enable && is_master && !dissel && !ss_n_s |=> fault_q && !enable;
   endproperty
   a_fault_set: assert property (p_fault_set) else $error("low select missed as fault"); // R19

   property p_fault_effect;
      $rose(fault_q) |-> !enable && !is_master ##1 irq_o;
   endproperty
   a_fault_effect: assert property (p_fault_effect) else $error("fault left port enabled"); // R20

   property p_no_fault;
      is_master && dissel |=> !$rose(fault_q);
   endproperty
   a_no_fault: assert property (p_no_fault) else $error("fault set with select disabled"); // R12

   property p_collision;
      wr_data && busy && !ev && !abort |=> coll_q && busy;
   endproperty
   a_collision: assert property (p_collision) else $error("collision lost or transfer cut"); // R21
endmodule // smp_top

// [bench/smp_slave_model.sv]
`timescale 1ns/100ps
module smp_slave_model (
   // serial pins
   input wire logic sck_i,
   input wire logic sel_n_i,
   input wire logic mosi_i,
   output logic miso_o,
   // format and data
   input wire logic clock_polarity_bit_i,
   input wire logic clock_phase_bit_i,
   input wire logic [7:0] tx_i,
   output logic [7:0] rx_o,
   output int pulses_o
);
   int idx;
   logic lead;
   initial
   begin
      miso_o = 1'b0;
      rx_o = 8'h00;
      pulses_o = 0;
      idx = 0;
   end
   // phase 0 needs b7 out before the first edge
   always @(negedge sel_n_i)
   begin
      pulses_o = 0;
      idx = clock_phase_bit_i ? 7 : 6;
      if (!clock_phase_bit_i)
         miso_o = tx_i[7];
   end
   // no pull on this line: show the inverse once released
   always @(posedge sel_n_i)
      miso_o = ~miso_o;
   always @(sck_i)
   begin
      if (!sel_n_i)
      begin
         lead = (sck_i != clock_polarity_bit_i);
         if (lead)
            pulses_o++;
         if (lead ^ clock_phase_bit_i)
            rx_o = {rx_o[6:0], mosi_i};
         else if (idx >= 0)
         begin
            miso_o = tx_i[idx];
            idx--;
         end
      end
   end
endmodule // smp_slave_model

// [bench/smp_top_tb_top.sv]
`timescale 1ns/100ps
`include "smp_defs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module smp_top_tb_top;
   logic ref_clk_i, rst_i, reg_wr_i, reg_rd_i, sck_l, mosi_l, ss_n, sel_n, clock_polarity_bit, clock_phase_bit;
   logic [1:0] reg_addr_i;
   logic [7:0] reg_wdata_i, reg_rdata_o, mtx, mrx, s, got;
   logic irq_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_m, miso_o, miso_oe_o;
   int err_total, tests_run, cyc, hi_cnt, hi_base, pulses;
   smp_top i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .sck_i(sck_l), .sck_o(sck_o),
      .sck_oe_o(sck_oe_o), .mosi_i(mosi_l), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o),
      .miso_i(miso_m), .miso_o(miso_o), .miso_oe_o(miso_oe_o), .ss_n_i(ss_n));
   smp_slave_model i_slv (.sck_i(sck_o), .sel_n_i(sel_n), .mosi_i(mosi_o), .miso_o(miso_m),
      .clock_polarity_bit_i(clock_polarity_bit), .clock_phase_bit_i(clock_phase_bit), .tx_i(mtx), .rx_o(mrx), .pulses_o(pulses));
   initial
   begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i)
   begin
      cyc++;
      if (sck_o !== clock_polarity_bit)
         hi_cnt <= hi_cnt + 1;
      if (cyc == 60000)
      begin
         err_total++;
         test_done();
      end
   end
   task automatic test_done();
      if (err_total == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask
   function automatic logic [7:0] cw(input logic [2:0] r, input logic pol, pha, mst, dis);
      return {r[2], 1'b1, dis, mst, pol, pha, r[1:0]};
   endfunction
   task automatic wait_done();
      for (int i = 0; i < 1000; i++)
      begin
         rd(`SMP_ADDR_STAT, s);
         if (s[`SMP_STA_DONE] === 1'b1)
            break;
      end
   endtask
   // one master byte; the model select toggles around every byte
   task automatic mxfer(input logic [2:0] r, input logic pol, pha, dis,
                        input logic [7:0] tx, rx);
      wr(`SMP_ADDR_CTRL, cw(r, pol, pha, 1'b1, dis));
      clock_polarity_bit = pol;
      clock_phase_bit = pha;
      mtx = rx;
      // clock settles at the new idle level before select drops
      repeat (2) @(posedge ref_clk_i);
      hi_base = hi_cnt;
      sel_n <= 1'b0;
      wr(`SMP_ADDR_DATA, tx);
      wait_done();
      `CHK(s[`SMP_STA_DONE], 1'b1)
      `CHK(irq_o, 1'b1)
      `CHK(mrx, tx)
      `CHK(pulses, 8)
      `CHK(hi_cnt - hi_base, 8 << r)
      `CHK(sck_o, pol)
      `CHK(mosi_oe_o, 1'b1)
      rd(`SMP_ADDR_DATA, got);
      if (r != 3'h1)
         `CHK(got, rx)
      sel_n <= 1'b1;
   endtask
   initial
   begin
      {reg_wr_i, reg_rd_i, sck_l, mosi_l, clock_polarity_bit, clock_phase_bit} = '0;
      {ss_n, sel_n} = 2'b11;
      reg_addr_i = 2'h0;
      reg_wdata_i = 8'h00;
      mtx = 8'h00;
      rst_i = 1'b1;
      repeat (16) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      rd(`SMP_ADDR_CTRL, got);
      `CHK(got, `SMP_CTRL_RST)
      rd(2'h3, got);
      `CHK(got, 8'h00)
      for (int f = 0; f < 4; f++)
         mxfer(3'h2, f[1], f[0], 1'b0, 8'hA5 ^ f[7:0], 8'h3C + f[7:0]);
      for (int r = 1; r < 7; r++)
         mxfer(r[2:0], 1'b0, 1'b1, 1'b0, 8'h81, 8'h7E);
      for (int r = 0; r < 8; r += 7)
      begin
         wr(`SMP_ADDR_CTRL, cw(r[2:0], 1'b0, 1'b0, 1'b1, 1'b0));
         wr(`SMP_ADDR_DATA, 8'h55);
         hi_base = hi_cnt;
         repeat (40) @(posedge ref_clk_i);
         `CHK(hi_cnt - hi_base, 0)
      end
      // collision: second write discarded, first byte still goes out
      wr(`SMP_ADDR_CTRL, cw(3'h2, 1'b0, 1'b0, 1'b1, 1'b0));
      mtx = 8'h00;
      clock_phase_bit = 1'b0;
      sel_n <= 1'b0;
      wr(`SMP_ADDR_DATA, 8'hC3);
      repeat (10) @(posedge ref_clk_i);
      wr(`SMP_ADDR_DATA, 8'h18);
      repeat (2) @(posedge ref_clk_i);
      `CHK(irq_o, 1'b0)
      wait_done();
      `CHK(s, 8'hC0)
      `CHK(mrx, 8'hC3)
      rd(`SMP_ADDR_DATA, got);
      rd(`SMP_ADDR_STAT, got);
      `CHK(got, 8'h00)
      sel_n <= 1'b1;
      // slave role, link clock from outside
      wr(`SMP_ADDR_CTRL, cw(3'h2, 1'b0, 1'b0, 1'b0, 1'b0));
      repeat (4) @(posedge ref_clk_i);
      `CHK(miso_oe_o, 1'b0)
      ss_n <= 1'b0;
      wr(`SMP_ADDR_DATA, 8'h96);
      repeat (4) @(posedge ref_clk_i);
      `CHK(miso_oe_o, 1'b1)
      #1.3;
      for (int i = 7; i >= 0; i--)
      begin
         mosi_l <= ~i[0] ^ i[1];
         #32 sck_l <= 1'b1;
         got[i] = miso_o;
         #32 sck_l <= 1'b0;
      end
      `CHK(got, 8'h96)
      wait_done();
      rd(`SMP_ADDR_DATA, got);
      `CHK(got, 8'h99)
      ss_n <= 1'b1;
      wr(`SMP_ADDR_CTRL, cw(3'h2, 1'b0, 1'b1, 1'b0, 1'b1));
      repeat (4) @(posedge ref_clk_i);
      `CHK(miso_oe_o, 1'b1)
      // mode fault
      wr(`SMP_ADDR_CTRL, cw(3'h2, 1'b0, 1'b0, 1'b1, 1'b0));
      ss_n <= 1'b0;
      repeat (6) @(posedge ref_clk_i);
      `CHK(irq_o, 1'b1)
      `CHK(sck_oe_o, 1'b0)
      `CHK(mosi_oe_o, 1'b0)
      wr(`SMP_ADDR_CTRL, 8'h26);
      wr(`SMP_ADDR_CTRL, 8'h06);
      rd(`SMP_ADDR_STAT, got);
      `CHK(got, 8'h10)
      `CHK(irq_o, 1'b1)
      ss_n <= 1'b1;
      wr(`SMP_ADDR_CTRL, 8'h02);
      rd(`SMP_ADDR_STAT, got);
      `CHK(got, 8'h00)
      // select pin ignored by a master with select disabled
      ss_n <= 1'b0;
      mxfer(3'h2, 1'b0, 1'b1, 1'b1, 8'hE7, 8'h42);
      rd(`SMP_ADDR_STAT, got);
      `CHK(got, 8'h00)
      test_done();
   end
endmodule // smp_top_tb_top
